//--- ir_remote_pkg.sv
// Constants shared by the infrared remote transmit/receive unit.
package ir_remote_pkg;
   // Register indexes; the byte address on the bus is four times each.
   localparam logic [15:0] CONFIG_IDX  = 16'h5340;
   localparam logic [15:0] PRESC_IDX   = 16'h5341;
   localparam logic [15:0] HIGH_IDX    = 16'h5342;
   localparam logic [15:0] LOW_IDX     = 16'h5343;
   localparam logic [15:0] STATUS_IDX  = 16'h5344;
   localparam logic [15:0] COUNT_IDX   = 16'h5345;
   localparam logic [15:0] MASK_IDX    = 16'h5346;
   localparam logic [15:0] FLAGS_IDX   = 16'h5347;
   localparam int          NUM_REGS    = 8;
   // Field positions.
   localparam int RUN_BIT   = 0;
   localparam int DIR_BIT   = 1;
   localparam int DATA_BIT  = 0;
   localparam int UNDER_BIT = 0;
   localparam int RISE_BIT  = 1;
   localparam int FALL_BIT  = 2;
   localparam int CAR_SEL_LSB = 4;
   localparam int CNT_SEL_LSB = 0;
   // Widths and counts.
   localparam int SEL_W      = 4;
   localparam int PRESCALE_W = 14;
   localparam int NUM_TAPS   = 15;
   localparam int LEN_W      = 6;
   localparam int CNT_W      = 8;
   localparam int REG_W      = 8;
   localparam logic [SEL_W-1:0] SEL_RESERVED = 4'hf;
   // Values after reset.
   localparam logic [1:0]       CONFIG_RST = 2'h0;
   localparam logic [REG_W-1:0] PRESC_RST  = 8'h00;
   localparam logic [LEN_W-1:0] LEN_RST    = 6'h00;
   localparam logic [CNT_W-1:0] COUNT_RST  = 8'h00;
   localparam logic [2:0]       MASK_RST   = 3'h0;
   localparam logic [2:0]       FLAGS_RST  = 3'h0;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

//--- prescale_if.sv
// Interface carrying the prescaler's tick taps.
`timescale 1ns/10ps
interface prescale_if #(
   parameter int TAPS = ir_remote_pkg::NUM_TAPS
);
   logic [TAPS-1:0] tick; // One-cycle enables, tap n every 2**n cycles.
   modport source (output tick);
   modport sink   (input tick);
endinterface // prescale_if

//--- prescale_taps.sv
// Free-running prescaler producing power-of-two tick enables.
`timescale 1ns/10ps
module prescale_taps #(
   parameter int W = ir_remote_pkg::PRESCALE_W
) (
   // Clock and reset.
   input wire logic   aclk,
   input wire logic   aresetn,
   // Run control.
   input wire logic   run,
   // Tick taps.
   prescale_if.source taps
);
   logic [W-1:0] div_reg; // Divider count, held at zero when idle.

   // Count only while running so each run starts in a known phase.
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // Tap n pulses when the low n bits are all ones.
   for (genvar i = 0; i <= W; i++) begin : g_tap
      if (i == 0) begin : g_zero
         assign taps.tick[i] = run;
      end else begin : g_div
         assign taps.tick[i] = run && (&div_reg[i-1:0]);
      end
   end
endmodule // prescale_taps

//--- carrier_gen.sv
// Carrier generator alternating programmable high and low phases.
`timescale 1ns/10ps
module carrier_gen (
   // Clock and reset.
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // Control.
   input  wire logic                           run,
   input  wire logic [ir_remote_pkg::SEL_W-1:0] sel,
   input  wire logic [ir_remote_pkg::LEN_W-1:0] high_len,
   input  wire logic [ir_remote_pkg::LEN_W-1:0] low_len,
   // Prescaler taps.
   prescale_if.sink                            taps,
   // Carrier level.
   output logic                                carrier
);
   typedef enum logic {PHASE_HIGH, PHASE_LOW} phase_t;
   phase_t                            phase_reg; // Current phase.
   logic [ir_remote_pkg::LEN_W-1:0]   len_reg;   // Carrier clocks spent in phase.
   logic                              tick;      // Selected carrier clock.
   logic [ir_remote_pkg::LEN_W-1:0]   limit;     // Last count of the phase.

   // The reserved code yields no carrier clock at all.
   assign tick  = (sel != ir_remote_pkg::SEL_RESERVED) && taps.tick[sel];
   assign limit = (phase_reg == PHASE_HIGH) ? high_len : low_len;
   assign carrier = (phase_reg == PHASE_HIGH);

   // Each phase lasts its length plus one carrier clocks, high first.
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         phase_reg <= PHASE_HIGH;
         len_reg   <= '0;
      end else if (tick) begin
         if (len_reg == limit) begin
            len_reg <= '0;
            unique case (phase_reg)
               PHASE_HIGH: phase_reg <= PHASE_LOW;
               PHASE_LOW:  phase_reg <= PHASE_HIGH;
            endcase
         end else begin
            len_reg <= len_reg + 1'b1;
         end
      end
   end
endmodule // carrier_gen

//--- ir_remote_unit.sv
// Infrared remote transmit/receive unit with an AXI4-Lite register bank.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// - Direction bit one receives, zero transmits.
// - Run enable starts; clearing stops everything.
// - Carrier clock is divided by two**code.
// - Counter clock uses same divider, resets undivided.
// - High phase lasts length plus one.
// - Low phase lasts length plus one.
// - Transmit drives carrier gated by data bit.
// - Receive copies input level into data bit.
// - Counter write loads, then counts down.
// - Counter halts at zero, raises underflow.
// - Receive detects rising and falling edges.
// - Mask holds three independent enables.
// - Reserved bits written zero, read zero.
// - Eight 8-bit registers at consecutive indexes.
// - Flags set only when their enable is set.
// - One request line, high while any flag set.
module ir_remote_unit #(
   parameter int ADDR_W = 32
) (
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address channel.
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   // Write data channel.
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // Write response channel.
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // Read address channel.
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   // Read data channel.
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Infrared pins.
   input  wire logic              remote_input_pin,
   output logic                   modulated_output_pin,
   // Request line to the interrupt controller.
   output logic                   irq
);
   localparam int SW = ir_remote_pkg::SEL_W;
   localparam int CW = ir_remote_pkg::CNT_W;

   // Register contents.
   logic [1:0]                      cfg_reg;   // Direction and run bits.
   logic [ir_remote_pkg::REG_W-1:0] psc_reg;   // Both clock selects.
   logic [ir_remote_pkg::LEN_W-1:0] high_reg;  // High phase length.
   logic [ir_remote_pkg::LEN_W-1:0] low_reg;   // Low phase length.
   logic                            data_reg;  // Transmit or received bit.
   logic [CW-1:0]                   count_reg; // Length down counter.
   logic [2:0]                      mask_reg;  // Interrupt enables.
   logic [2:0]                      flag_reg;  // Sticky interrupt flags.

   // Bus holding registers.
   logic              aw_held;  // Write address captured.
   logic              w_held;   // Write data captured.
   logic [ADDR_W-1:0] wa_reg;   // Captured write address.
   logic [7:0]        wd_reg;   // Captured write data, low lane.
   logic              ws_reg;   // Low lane strobe.

   // Input synchroniser and edge history.
   logic in_meta;  // First stage, read only by the second.
   logic in_sync;  // Second stage.
   logic in_prev;  // Previous synchronised level.

   // Decoded controls.
   logic              run;       // Unit running.
   logic              rx_mode;   // Receive direction.
   logic              wr_fire;   // Register write happens this cycle.
   logic [2:0]        wr_slot;   // Written register slot.
   logic              wr_hit;    // Write address is mapped.
   logic [2:0]        rd_slot;   // Read register slot.
   logic              rd_hit;    // Read address is mapped.
   logic [ADDR_W-3:0] wr_off;    // Word offset from the first index.
   logic [ADDR_W-3:0] rd_off;    // Word offset from the first index.
   logic [7:0]        rd_byte;   // Read data before widening.
   logic              cnt_tick;  // Selected counter clock.
   logic              carrier;   // Carrier level.
   logic              underflow; // Counter reaching zero.
   logic              rise;      // Rising input edge.
   logic              fall;      // Falling input edge.
   logic [2:0]        events;    // Enabled events this cycle.
   logic [2:0]        clears;    // Flags cleared by software.

   prescale_if taps_if ();

   assign run     = cfg_reg[ir_remote_pkg::RUN_BIT];
   assign rx_mode = cfg_reg[ir_remote_pkg::DIR_BIT];

   // Registers sit at consecutive word indexes.
   assign wr_off  = wa_reg[ADDR_W-1:2] - (ADDR_W-2)'(ir_remote_pkg::CONFIG_IDX);
   assign rd_off  = araddr[ADDR_W-1:2] - (ADDR_W-2)'(ir_remote_pkg::CONFIG_IDX);
   assign wr_hit  = wr_off < (ADDR_W-2)'(ir_remote_pkg::NUM_REGS);
   assign rd_hit  = rd_off < (ADDR_W-2)'(ir_remote_pkg::NUM_REGS);
   assign wr_slot = wr_off[2:0];
   assign rd_slot = rd_off[2:0];
   assign wr_fire = aw_held && w_held && !bvalid;

   // Free-running prescaler stopped while idle.
   prescale_taps u_taps (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run),
      .taps    (taps_if.source)
   );

   // Carrier generator.
   carrier_gen u_carrier (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (run),
      .sel      (psc_reg[ir_remote_pkg::CAR_SEL_LSB +: SW]),
      .high_len (high_reg),
      .low_len  (low_reg),
      .taps     (taps_if.sink),
      .carrier  (carrier)
   );

   // Counter clock from the same divider; reserved code never ticks.
   always_comb begin
      if (psc_reg[ir_remote_pkg::CNT_SEL_LSB +: SW] == ir_remote_pkg::SEL_RESERVED) begin
         cnt_tick = 1'b0;
      end else begin
         cnt_tick = taps_if.tick[psc_reg[ir_remote_pkg::CNT_SEL_LSB +: SW]];
      end
   end

   // Write address channel: capture once, release on the response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         awready <= 1'b1;
         wa_reg  <= '0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         awready <= 1'b0;
         wa_reg  <= awaddr;
      end else if (bvalid && bready) begin
         aw_held <= 1'b0;
         awready <= 1'b1;
      end
   end

   // Write data channel: captured independently of the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wready <= 1'b1;
         wd_reg <= 8'h00;
         ws_reg <= 1'b0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         wready <= 1'b0;
         wd_reg <= wdata[7:0];
         ws_reg <= wstrb[0];
      end else if (bvalid && bready) begin
         w_held <= 1'b0;
         wready <= 1'b1;
      end
   end

   // Write response follows once both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= ir_remote_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? ir_remote_pkg::RESP_OKAY : ir_remote_pkg::RESP_DECERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read mux; reserved bits read as zero.
   always_comb begin
      unique case (rd_slot)
         3'h0: rd_byte = {6'h00, cfg_reg};
         3'h1: rd_byte = psc_reg;
         3'h2: rd_byte = {2'h0, high_reg};
         3'h3: rd_byte = {2'h0, low_reg};
         3'h4: rd_byte = {7'h00, data_reg};
         3'h5: rd_byte = count_reg;
         3'h6: rd_byte = {5'h00, mask_reg};
         3'h7: rd_byte = {5'h00, flag_reg};
      endcase
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= ir_remote_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         rresp   <= rd_hit ? ir_remote_pkg::RESP_OKAY : ir_remote_pkg::RESP_DECERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // Configuration, clock select, carrier lengths and mask registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg  <= ir_remote_pkg::CONFIG_RST;
         psc_reg  <= ir_remote_pkg::PRESC_RST;
         high_reg <= ir_remote_pkg::LEN_RST;
         low_reg  <= ir_remote_pkg::LEN_RST;
         mask_reg <= ir_remote_pkg::MASK_RST;
      end else if (wr_fire && wr_hit && ws_reg) begin
         unique case (wr_slot)
            3'h0: cfg_reg  <= wd_reg[1:0];
            3'h1: psc_reg  <= wd_reg;
            3'h2: high_reg <= wd_reg[5:0];
            3'h3: low_reg  <= wd_reg[5:0];
            3'h6: mask_reg <= wd_reg[2:0];
            default: begin
               // Other slots are handled by their own processes.
            end
         endcase
      end
   end

   // Two-flop synchroniser and edge history, reset to the input's idle high level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_meta <= 1'b1;
         in_sync <= 1'b1;
         in_prev <= 1'b1;
      end else begin
         in_meta <= remote_input_pin;
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   // Edges count only while running in receive mode.
   assign rise = run && rx_mode && in_sync && !in_prev;
   assign fall = run && rx_mode && !in_sync && in_prev;

   // Data bit: mirrors the input in receive, holds software's bit otherwise.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_reg <= 1'b0;
      end else if (run && rx_mode) begin
         data_reg <= in_sync;
      end else if (wr_fire && wr_hit && ws_reg && wr_slot == 3'h4) begin
         data_reg <= wd_reg[ir_remote_pkg::DATA_BIT];
      end
   end

   // Underflow when a running count steps from one to zero.
   assign underflow = run && cnt_tick && (count_reg == 8'h01) &&
                      !(wr_fire && wr_hit && ws_reg && wr_slot == 3'h5);

   // Length counter: a write loads it, ticks count it down to zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= ir_remote_pkg::COUNT_RST;
      end else if (wr_fire && wr_hit && ws_reg && wr_slot == 3'h5) begin
         count_reg <= wd_reg;
      end else if (run && cnt_tick && count_reg != 8'h00) begin
         count_reg <= count_reg - 8'h01;
      end
   end

   // Events reach a flag only through its enable.
   assign events[ir_remote_pkg::UNDER_BIT] =
      underflow && mask_reg[ir_remote_pkg::UNDER_BIT];
   assign events[ir_remote_pkg::RISE_BIT] =
      rise && mask_reg[ir_remote_pkg::RISE_BIT];
   assign events[ir_remote_pkg::FALL_BIT] =
      fall && mask_reg[ir_remote_pkg::FALL_BIT];
   assign clears = (wr_fire && wr_hit && ws_reg && wr_slot == 3'h7) ?
                   wd_reg[2:0] : 3'h0;

   // Sticky flags; a new event wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= ir_remote_pkg::FLAGS_RST;
      end else begin
         flag_reg <= (flag_reg & ~clears) | events;
      end
   end

   // Single request line follows the flags one cycle later.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |flag_reg;
      end
   end

   // Modulated output: carrier gated by the data bit while transmitting.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulated_output_pin <= 1'b0;
      end else begin
         modulated_output_pin <= run && !rx_mode && data_reg && carrier;
      end
   end
endmodule // ir_remote_unit

//--- ir_remote_properties.sv
// Concurrent checks on the remote unit's bus answers and pin outputs.
`timescale 1ns/10ps
module ir_remote_properties #(
   parameter int ADDR_W = 32
) (
   // Clock and reset.
   input wire logic              aclk,
   input wire logic              aresetn,
   // Write channels.
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   // Read channels.
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   // Pins.
   input wire logic              modulated_output_pin,
   input wire logic              irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ar_bad; // High when the read address lies outside the register window.
   // Decode the window from the first and last register index; the low two bits are ignored.
   assign ar_bad = (araddr[ADDR_W-1:2] < ir_remote_pkg::CONFIG_IDX) ||
                   (araddr[ADDR_W-1:2] > ir_remote_pkg::FLAGS_IDX);
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer late");
   a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   a_busy_no_take: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answering");
   a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_unmapped_read: assert property (arvalid && arready && ar_bad
      |=> rresp == ir_remote_pkg::RESP_DECERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_read: assert property (arvalid && arready && !ar_bad
      |=> rresp == ir_remote_pkg::RESP_OKAY)
      else $error("mapped read refused");
   a_irq_clear_write: assert property ($fell(irq) |-> $past(bvalid))
      else $error("request fell without a write");
   a_quiet_reset: assert property ($rose(aresetn) |-> !irq && !modulated_output_pin)
      else $error("outputs active after reset");
   // Main scenarios reached.
   c_irq: cover property ($rose(irq));
   c_decerr: cover property (rvalid && rresp == ir_remote_pkg::RESP_DECERR);
   c_led: cover property ($rose(modulated_output_pin));
endmodule // ir_remote_properties

bind ir_remote_unit ir_remote_properties #(.ADDR_W(ADDR_W)) ir_remote_properties_i (
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
   .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .modulated_output_pin, .irq
);

//--- ir_partner.sv
// Behavioural infrared LED and receiver module facing the remote unit.
`timescale 1ns/10ps
module ir_partner (
   // Clock.
   input  wire logic aclk,
   // LED drive from the unit.
   input  wire logic modulated_output_pin,
   // Receiver output to the unit.
   output logic      remote_input_pin,
   // Last finished LED phases, in cycles.
   output int        hi_run,
   output int        lo_run
);
   int   run_len = 0;    // Cycles spent at the present LED level.
   logic led_q   = 1'b0; // LED level at the previous edge.
   // The receiver output idles high, like a pulled-up line.
   initial begin
      remote_input_pin = 1'b1;
      hi_run = 0;
      lo_run = 0;
   end
   // Measure each LED phase as it ends.
   always @(posedge aclk) begin
      if (modulated_output_pin === led_q) begin
         run_len <= run_len + 1;
      end else begin
         if (led_q) hi_run <= run_len;
         else lo_run <= run_len;
         run_len <= 1;
      end
      led_q <= modulated_output_pin;
   end
   // Move the receiver output to a new level just after an edge.
   task automatic hold(input logic v);
      @(posedge aclk);
      remote_input_pin <= v;
   endtask
endmodule // ir_partner

//--- testbench.sv
// Self-checking bench for the infrared remote transmit/receive unit.
`timescale 1ns/10ps
module testbench;
   localparam int CFG = 0, PSC = 1, HI = 2, LO = 3, ST = 4, CNT = 5, MSK = 6, FLG = 7, BAD = 8;
   localparam logic [1:0] OK = ir_remote_pkg::RESP_OKAY;
   localparam logic [1:0] DE = ir_remote_pkg::RESP_DECERR;
   logic        aclk = 1'b0, aresetn = 1'b0;          // Clock and reset.
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0; // Bus payloads.
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  wstrb = 4'hf;                        // Write strobes.
   logic [2:0]  awprot = 3'h2, arprot = 3'h2;         // Protection, ignored by the unit.
   logic        awready, wready, bvalid, arready, rvalid;
   logic        modulated_output_pin, irq, remote_input_pin;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          hi_run, lo_run;
   int          n_errors = 0, n_checks = 0;
   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;
   ir_remote_unit #(.ADDR_W(32)) ir_remote_unit_i (
      .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .remote_input_pin, .modulated_output_pin, .irq
   );
   ir_partner ir_partner_i (.aclk, .modulated_output_pin, .remote_input_pin, .hi_run, .lo_run);
   // Compare and count.
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run.
   task automatic test_done;
      $display("Checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Byte address of the register k words past the first.
   function automatic logic [31:0] ba(int k);
      return {14'h0, ir_remote_pkg::CONFIG_IDX + 16'(k), 2'b00};
   endfunction
   // One write; both channels offered together, each released when taken.
   task automatic wr(int k, logic [7:0] d, logic [1:0] er);
      int t = 0;
      @(posedge aclk);
      awaddr <= ba(k);
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end while (bvalid !== 1'b1 && t < 50);
      bready <= 1'b0;
      check(bvalid, 1'b1);
      check(bresp, er);
   endtask
   // One read; data taken at the edge that shows rvalid.
   task automatic rd(int k, output logic [31:0] d, output logic [1:0] r);
      int t = 0;
      @(posedge aclk);
      araddr <= ba(k);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         t++;
      end while (rvalid !== 1'b1 && t < 50);
      check(rvalid, 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Read a register and compare its byte.
   task automatic rc(int k, logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(k, d, r);
      check(d, {24'h0, e});
      check(r, OK);
   endtask
   // Values after reset, and refusal outside the window.
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      for (int k = CFG; k <= FLG; k++) rc(k, 8'h00);
      rd(BAD, d, r);
      check(d, 32'h0);
      check(r, DE);
      wr(BAD, 8'h01, DE);
      wstrb <= 4'h0;
      wr(HI, 8'h15, OK);
      wstrb <= 4'hf;
      rc(HI, 8'h00);
   endtask
   // Every field but the run bit written with ones; reserved bits read back zero.
   task automatic t_fields;
      logic [7:0] keep [8] = '{8'h02, 8'hff, 8'h3f, 8'h3f, 8'h01, 8'hff, 8'h07, 8'h00};
      for (int k = CFG; k <= FLG; k++) begin
         wr(k, (k == CFG) ? 8'hfe : 8'hff, OK);
         rc(k, keep[k]);
         wr(k, 8'h00, OK);
      end
   endtask
   // Carrier phases at three clock selects, then a gated-off data bit.
   task automatic t_carrier;
      logic [3:0] cs [3] = '{4'h0, 4'h1, 4'h2};
      logic [5:0] ch [3] = '{6'h02, 6'h00, 6'h3f};
      logic [5:0] cl [3] = '{6'h01, 6'h03, 6'h00};
      int         n = 0;
      for (int i = 0; i < 3; i++) begin
         wr(PSC, {cs[i], 4'h0}, OK);
         wr(HI, {2'b00, ch[i]}, OK);
         wr(LO, {2'b00, cl[i]}, OK);
         wr(ST, 8'h01, OK);
         wr(CFG, 8'h01, OK);
         if (i == 2) begin
            repeat (2) @(posedge aclk);
            check(modulated_output_pin, 1'b1);
         end
         repeat (3 * ((ch[i] + cl[i] + 2) << cs[i]) + 10) @(posedge aclk);
         check(hi_run, (ch[i] + 1) << cs[i]);
         check(lo_run, (cl[i] + 1) << cs[i]);
         wr(CFG, 8'h00, OK);
      end
      wr(ST, 8'h00, OK);
      wr(CFG, 8'h01, OK);
      for (int j = 0; j < 40; j++) begin
         @(posedge aclk);
         if (modulated_output_pin !== 1'b0) n++;
      end
      check(n, 0);
      wr(ST, 8'h01, OK);
      wr(CFG, 8'h00, OK);
      repeat (3) @(posedge aclk);
      check(modulated_output_pin, 1'b0);
      wr(PSC, 8'h01, OK);
   endtask
   // Count down to zero with and without the underflow enable.
   task automatic t_counter;
      int t = 0;
      wr(CNT, 8'h07, OK);
      rc(CNT, 8'h07);
      wr(MSK, 8'h01, OK);
      wr(CFG, 8'h01, OK);
      while (irq !== 1'b1 && t < 200) begin
         @(posedge aclk);
         t++;
      end
      check(irq, 1'b1);
      check(t, 2 * 7 + 1);
      rc(CNT, 8'h00);
      rc(FLG, 8'h01);
      wr(FLG, 8'h00, OK);
      rc(FLG, 8'h01);
      wr(FLG, 8'h01, OK);
      rc(FLG, 8'h00);
      check(irq, 1'b0);
      wr(MSK, 8'h00, OK);
      wr(CNT, 8'h03, OK);
      repeat (20) @(posedge aclk);
      rc(FLG, 8'h00);
      rc(CNT, 8'h00);
      wr(CFG, 8'h00, OK);
   endtask
   // Reception: level mirror and edge causes under two masks.
   task automatic t_receive;
      wr(MSK, 8'h06, OK);
      wr(CFG, 8'h03, OK);
      ir_partner_i.hold(1'b0);
      repeat (8) @(posedge aclk);
      rc(ST, 8'h00);
      rc(FLG, 8'h04);
      wr(CNT, 8'hff, OK);
      ir_partner_i.hold(1'b1);
      repeat (8) @(posedge aclk);
      rc(ST, 8'h01);
      rc(FLG, 8'h06);
      check(irq, 1'b1);
      wr(FLG, 8'h06, OK);
      wr(MSK, 8'h02, OK);
      ir_partner_i.hold(1'b0);
      repeat (8) @(posedge aclk);
      rc(FLG, 8'h00);
      ir_partner_i.hold(1'b1);
      repeat (8) @(posedge aclk);
      rc(FLG, 8'h02);
      wr(FLG, 8'h07, OK);
      wr(CFG, 8'h00, OK);
   endtask
   // Main sequence.
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_fields;
      t_carrier;
      t_counter;
      t_receive;
      test_done;
   end
   // Watchdog against a hung handshake.
   initial begin
      #300000;
      n_errors++;
      test_done;
   end
endmodule // testbench
